// [uhe_pkg.sv]
package uhe_pkg;
  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] UHE_EP0_CTRL_ADDR = 8'h00;
  localparam logic [7:0] UHE_EP1_CTRL_ADDR = 8'h04;
  localparam logic [7:0] UHE_EP0_STATUS_ADDR = 8'h08;
  localparam logic [7:0] UHE_INT_STATUS_ADDR = 8'h0c;
  localparam logic [7:0] UHE_INT_MASK_ADDR = 8'h10;
  localparam logic [7:0] UHE_DATA_BASE_ADDR = 8'h20;
  localparam logic [7:0] UHE_DATA_LAST_ADDR = 8'h3c;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int UHE_RX_EN_BIT = 0;
  localparam int UHE_TX_EN_BIT = 1;
  localparam int UHE_TX_CNT_LSB = 4;
  localparam int UHE_EP1_FORCE_STALL_BIT = 7;
  localparam int UHE_PEND_BIT = 6;
  localparam int UHE_RX_TOG_BIT = 7;
  localparam int UHE_SETUP_BIT = 6;
  localparam int UHE_TX_BEFORE_RX_FLAG_BIT = 5;
  localparam int UHE_TX_BEFORE_RX_FLAG_CLR_BIT = 4;
  localparam int UHE_INT_RX_BIT = 0;
  localparam int UHE_INT_TX_BIT = 1;
  // ************************************************************
  // reset values and sizes
  // ************************************************************
  localparam logic [7:0] UHE_EP0_CTRL_RST = 8'h00;
  localparam logic [7:0] UHE_EP1_CTRL_RST = 8'h00;
  localparam logic [1:0] UHE_INT_RST = 2'h0;
  localparam int UHE_BUF_BYTES = 8;
  // ************************************************************
  // token kinds and handshake answers
  // ************************************************************
  typedef enum logic [1:0] {UHE_TOK_OUT, UHE_TOK_IN, UHE_TOK_SETUP, UHE_TOK_NONE} uhe_tok_t;
  typedef enum logic [1:0] {UHE_HS_ACK, UHE_HS_NAK, UHE_HS_STALL, UHE_HS_DATA} uhe_hs_t;
endpackage

// [uhe_hub_endpoints.sv]
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] ep0 OUT gets NAK while receive enable is 0 or receive done is set.
// [R2] software sets receive enable when ready and clears it when full.
// [R3] 4-bit transmit byte count sets size of next ep0 IN answer.
// [R4] ep1 stall bit forces STALL on every ep1 poll.
// [R5] ep1 IN gets NAK when pending is 0, else the change bitmap.
// [R6] software sets pending on any status change, clears it when none left.
// [R7] 6-bit change bitmap: hub, ports 1 to 4, embedded device.
// [R8] read-only toggle of last ep0 packet received, 1 for DATA1.
// [R9] read-only flag, 1 when last ep0 token was SETUP.
// [R10] tx-first flag set when rx done sets while tx done is still set.
// [R11] writing 1 to tx-first clear bit clears the tx-first flag.
// [R12] read-only byte count of last ep0 OUT or SETUP, kept through reset.
// [R13] eight receive bytes loaded serially from ep0 OUT or SETUP data.
// [R14] software fills eight transmit bytes, sent on next ep0 IN.
// [R15] ep0 IN gets NAK while transmit enable is 0 or tx done is set.
// [R16] receive done sets once a data packet is accepted and ACKed.
// [R17] data byte reads return receive buffer, writes fill transmit buffer.
module uhe_hub_endpoints
  import uhe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic [3:0] tok_ep,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_toggle,
  input wire logic host_ack,
  output logic resp_valid,
  output logic [1:0] resp_code,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic irq
);
  typedef enum logic [1:0] {UHE_IDLE, UHE_RECV, UHE_SEND} uhe_state_t;

  // ************************************************************
  // state
  // ************************************************************
  uhe_state_t state_q, state_d;
  logic [7:0] ep0_ctrl_q;
  logic [7:0] ep1_ctrl_q;
  logic ep0_rx_toggle_q, setup_seen_q, tx_before_rx_flag_q;
  logic [3:0] ep0_rx_byte_count_q;
  logic [1:0] int_status_q, int_mask_q;
  logic [7:0] ep0_rx_buffer [UHE_BUF_BYTES];
  logic [7:0] ep0_tx_buffer [UHE_BUF_BYTES];
  logic rx_accept_q, ack_wait_q;
  logic [3:0] idx_q, send_len_q;
  logic ep1_send_q;
  logic bus_wr_q;
  logic [7:0] bus_addr_q;
  logic [31:0] rd_mux;

  // ************************************************************
  // register fields
  // ************************************************************
  wire ep0_rx_enable = ep0_ctrl_q[UHE_RX_EN_BIT];
  wire ep0_tx_enable = ep0_ctrl_q[UHE_TX_EN_BIT];
  wire [3:0] ep0_tx_byte_count = ep0_ctrl_q[UHE_TX_CNT_LSB +: 4];
  wire ep1_force_stall = ep1_ctrl_q[UHE_EP1_FORCE_STALL_BIT];
  wire status_change_pending = ep1_ctrl_q[UHE_PEND_BIT];
  wire [5:0] change_bitmap = ep1_ctrl_q[5:0];
  wire ep0_rx_done_flag = int_status_q[UHE_INT_RX_BIT];
  wire ep0_tx_done_flag = int_status_q[UHE_INT_TX_BIT];

  // ************************************************************
  // bus decode
  // ************************************************************
  wire bus_take = hsel & htrans[1] & hready;
  wire wr_ep0 = bus_wr_q & (bus_addr_q == UHE_EP0_CTRL_ADDR);
  wire wr_ep1 = bus_wr_q & (bus_addr_q == UHE_EP1_CTRL_ADDR);
  wire wr_stat = bus_wr_q & (bus_addr_q == UHE_EP0_STATUS_ADDR);
  wire wr_int = bus_wr_q & (bus_addr_q == UHE_INT_STATUS_ADDR);
  wire wr_mask = bus_wr_q & (bus_addr_q == UHE_INT_MASK_ADDR);
  wire is_data = (bus_addr_q >= UHE_DATA_BASE_ADDR) & (bus_addr_q <= UHE_DATA_LAST_ADDR);
  wire wr_data = bus_wr_q & is_data;
  wire [2:0] data_idx = bus_addr_q[4:2];
  wire tx_before_rx_flag_clr = wr_stat & hwdata[UHE_TX_BEFORE_RX_FLAG_CLR_BIT];
  wire [1:0] int_clr = wr_int ? hwdata[1:0] : 2'h0;

  // ************************************************************
  // token decode
  // ************************************************************
  wire ep0_tok = tok_valid & (tok_ep == 4'h0);
  wire ep1_tok = tok_valid & (tok_ep == 4'h1);
  wire is_setup = tok_kind == UHE_TOK_SETUP;
  wire is_out = tok_kind == UHE_TOK_OUT;
  wire is_in = tok_kind == UHE_TOK_IN;
  wire idle = state_q == UHE_IDLE;
  wire start_rx = idle & ep0_tok & (is_setup | is_out);
  wire out_ok = is_setup | (ep0_rx_enable & ~ep0_rx_done_flag); // R1
  wire ep0_in_ok = ep0_tx_enable & ~ep0_tx_done_flag; // R15
  wire ep0_in = idle & ep0_tok & is_in;
  wire ep1_in = idle & ep1_tok & is_in;
  wire ep1_stall = idle & ep1_tok & ep1_force_stall; // R4
  wire ep1_send = ep1_in & ~ep1_force_stall & status_change_pending; // R5
  wire rx_finish = (state_q == UHE_RECV) & rx_end;
  wire rx_ack = rx_finish & rx_accept_q;
  wire rx_store = (state_q == UHE_RECV) & rx_valid & rx_accept_q & (idx_q < 4'h8);
  wire send_done = (state_q == UHE_SEND) & (idx_q >= send_len_q);
  wire tx_acked = host_ack & ack_wait_q;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      UHE_IDLE: begin
        if (start_rx) begin
          state_d = UHE_RECV;
        end else if ((ep0_in & ep0_in_ok) | ep1_send) begin
          state_d = UHE_SEND;
        end
      end
      UHE_RECV: begin
        if (rx_end) begin
          state_d = UHE_IDLE;
        end
      end
      UHE_SEND: begin
        if (send_done) begin
          state_d = UHE_IDLE;
        end
      end
      default: state_d = UHE_IDLE;
    endcase
  end

  // state, transfer index and length
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= UHE_IDLE;
      idx_q <= 4'h0;
      send_len_q <= 4'h0;
      rx_accept_q <= 1'b0;
      ep1_send_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start_rx) begin
        idx_q <= 4'h0;
        rx_accept_q <= out_ok;
      end else if (ep0_in | ep1_send) begin
        idx_q <= 4'h0;
        send_len_q <= ep1_send ? 4'h1 : ep0_tx_byte_count; // R3
        ep1_send_q <= ep1_send;
      end else if (rx_store | (state_q == UHE_SEND & ~send_done)) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  // wait for host ACK after ep0 data went out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_wait_q <= 1'b0;
    end else if (send_done) begin
      ack_wait_q <= ~ep1_send_q;
    end else if (tok_valid | host_ack) begin
      ack_wait_q <= 1'b0;
    end
  end

  // ************************************************************
  // handshake and data out
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_code <= UHE_HS_NAK;
    end else begin
      resp_valid <= 1'b0;
      if (ep1_stall) begin
        resp_valid <= 1'b1;
        resp_code <= UHE_HS_STALL; // R4
      end else if (ep1_in) begin
        resp_valid <= 1'b1;
        resp_code <= status_change_pending ? UHE_HS_DATA : UHE_HS_NAK; // R5
      end else if (ep0_in) begin
        resp_valid <= 1'b1;
        resp_code <= ep0_in_ok ? UHE_HS_DATA : UHE_HS_NAK; // R15
      end else if (rx_finish) begin
        resp_valid <= 1'b1;
        resp_code <= rx_accept_q ? UHE_HS_ACK : UHE_HS_NAK; // R1
      end
    end
  end

  // one payload byte per cycle while sending
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      tx_valid <= (state_q == UHE_SEND) & ~send_done;
      tx_last <= (state_q == UHE_SEND) & (idx_q + 4'h1 == send_len_q);
      tx_data <= ep1_send_q ? {2'h0, change_bitmap} : ep0_tx_buffer[idx_q[2:0]]; // R14 R7
    end
  end

  // ************************************************************
  // buffers
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < UHE_BUF_BYTES; gi++) begin : g_buf
      // receive byte fills from the link, transmit byte from software
      always_ff @(posedge clk_sys) begin
        if (rx_store & (idx_q[2:0] == 3'(gi))) begin
          ep0_rx_buffer[gi] <= rx_data; // R13
        end
        if (wr_data & (data_idx == 3'(gi))) begin
          ep0_tx_buffer[gi] <= hwdata[7:0]; // R17 R14
        end
      end
    end
  endgenerate

  // ************************************************************
  // status of last reception
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ep0_rx_toggle_q <= 1'b0;
      setup_seen_q <= 1'b0;
      tx_before_rx_flag_q <= 1'b0;
    end else begin
      if (ep0_tok) begin
        setup_seen_q <= is_setup; // R9
      end
      if (rx_ack) begin
        ep0_rx_toggle_q <= rx_toggle; // R8
      end
      if (rx_ack & ep0_tx_done_flag & ~tx_acked) begin
        tx_before_rx_flag_q <= 1'b1; // R10
      end else if (tx_before_rx_flag_clr) begin
        tx_before_rx_flag_q <= 1'b0; // R11
      end
    end
  end

  // byte count has no reset
  always_ff @(posedge clk_sys) begin
    if (rx_ack) begin
      ep0_rx_byte_count_q <= idx_q; // R12
    end
  end

  // ************************************************************
  // control registers and interrupt flags
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ep0_ctrl_q <= UHE_EP0_CTRL_RST; // R1 R3
      ep1_ctrl_q <= UHE_EP1_CTRL_RST; // R4 R7
      int_mask_q <= UHE_INT_RST;
    end else begin
      if (wr_ep0) begin
        ep0_ctrl_q <= hwdata[7:0]; // R2
      end
      if (wr_ep1) begin
        ep1_ctrl_q <= hwdata[7:0]; // R6 R7
      end
      if (wr_mask) begin
        int_mask_q <= hwdata[1:0];
      end
    end
  end

  // sticky done flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_status_q <= UHE_INT_RST;
    end else begin
      int_status_q[UHE_INT_RX_BIT] <= rx_ack | (ep0_rx_done_flag & ~int_clr[UHE_INT_RX_BIT]); // R16
      int_status_q[UHE_INT_TX_BIT] <= tx_acked | (ep0_tx_done_flag & ~int_clr[UHE_INT_TX_BIT]);
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // ************************************************************
  // bus slave
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_wr_q <= 1'b0;
      bus_addr_q <= 8'h00;
    end else begin
      bus_wr_q <= bus_take & hwrite;
      if (bus_take) begin
        bus_addr_q <= haddr[7:0];
      end
    end
  end

  // read mux over the registered data-phase address
  always_comb begin
    rd_mux = 32'h0;
    if (bus_addr_q == UHE_EP0_CTRL_ADDR) begin
      rd_mux = {24'h0, ep0_ctrl_q};
    end else if (bus_addr_q == UHE_EP1_CTRL_ADDR) begin
      rd_mux = {24'h0, ep1_ctrl_q};
    end else if (bus_addr_q == UHE_EP0_STATUS_ADDR) begin
      rd_mux = {24'h0, ep0_rx_toggle_q, setup_seen_q, tx_before_rx_flag_q, 1'b0,
                ep0_rx_byte_count_q};
    end else if (bus_addr_q == UHE_INT_STATUS_ADDR) begin
      rd_mux = {30'h0, int_status_q};
    end else if (bus_addr_q == UHE_INT_MASK_ADDR) begin
      rd_mux = {30'h0, int_mask_q};
    end else if (is_data) begin
      rd_mux = {24'h0, ep0_rx_buffer[data_idx]}; // R17
    end
  end

  assign hrdata = rd_mux;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// [uhe_hub_endpoints_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module uhe_hub_endpoints_chk
  import uhe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic [3:0] tok_ep,
  input wire logic resp_valid,
  input wire logic [1:0] resp_code,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ****
  // shadow of both control registers
  // ****
  logic wr_q;
  logic [7:0] ad_q;
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [3:0] ep_q;
  logic [3:0] n_q;
  wire logic wr_d = hsel & htrans[1] & hready & hwrite;
  wire logic [7:0] c0_d = (wr_q && ad_q == UHE_EP0_CTRL_ADDR) ? hwdata[7:0] : c0_q;
  wire logic [7:0] c1_d = (wr_q && ad_q == UHE_EP1_CTRL_ADDR) ? hwdata[7:0] : c1_q;
  wire logic stall = c1_q[UHE_EP1_FORCE_STALL_BIT];
  wire logic e1_in = tok_valid && tok_ep == 4'h1 && tok_kind == UHE_TOK_IN;
  // write tracking and a count of bytes sent since the last answer
  always_ff @(posedge clk_sys) begin
    wr_q <= wr_d && !sys_rst;
    ad_q <= wr_d ? haddr[7:0] : ad_q;
    c0_q <= sys_rst ? 8'h00 : c0_d;
    c1_q <= sys_rst ? 8'h00 : c1_d;
    ep_q <= tok_valid ? tok_ep : ep_q;
    n_q <= resp_valid ? 4'h0 : n_q + {3'h0, tx_valid};
  end
  // ****
  // handshake and data checks
  // ****
  stall_ep1_a: assert property (e1_in && stall |=>
    resp_valid && resp_code == UHE_HS_STALL) else $error("ep1 poll not stalled");
  ep1_nak_a: assert property (e1_in && !stall && !c1_q[UHE_PEND_BIT] |=>
    resp_valid && resp_code == UHE_HS_NAK) else $error("ep1 idle poll not nak");
  ep1_map_a: assert property (e1_in && !stall && c1_q[UHE_PEND_BIT] |=>
    resp_code == UHE_HS_DATA ##1 tx_valid && tx_last && tx_data == {2'b00, c1_q[5:0]})
    else $error("ep1 bitmap wrong");
  ep0_nak_a: assert property (tok_valid && tok_ep == 4'h0 && tok_kind == UHE_TOK_IN
    && !c0_q[UHE_TX_EN_BIT] |=> resp_valid && resp_code == UHE_HS_NAK)
    else $error("ep0 in not nak");
  tx_cnt_a: assert property (tx_valid && tx_last && ep_q == 4'h0 |->
    n_q + 4'h1 == c0_q[7:4]) else $error("ep0 byte count wrong");
  resp_once_a: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  tx_order_a: assert property ($rose(tx_valid) |->
    $past(resp_valid) && resp_code == UHE_HS_DATA) else $error("data without data answer");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  cover property (e1_in && stall);
  cover property (tx_last && ep_q == 4'h0);
  cover property (resp_valid && resp_code == UHE_HS_NAK);
  cover property (resp_valid && resp_code == UHE_HS_ACK);
endmodule
`default_nettype wire

// [uhe_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uhe_host_model
  import uhe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resp_valid,
  input wire logic [1:0] resp_code,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output var logic tok_valid,
  output var logic [1:0] tok_kind,
  output var logic [3:0] tok_ep,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  output var logic rx_end,
  output var logic rx_toggle,
  output var logic host_ack
);
  logic [7:0] pay [8];
  logic [7:0] got [8];
  int gotn;
  logic [1:0] code;
  initial begin
    tok_valid = 1'b0;
    tok_kind = 2'h3;
    tok_ep = 4'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_toggle = 1'b0;
    host_ack = 1'b0;
  end
  // ****
  // one transaction; unqualified lines show inverted values
  // ****
  task automatic xfer(input logic [1:0] kind, input logic [3:0] ep, input int n, input logic tog);
    @(posedge clk_sys);
    tok_valid <= 1'b1;
    tok_kind <= kind;
    tok_ep <= ep;
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok_kind <= ~kind;
    tok_ep <= ~ep;
    for (int i = 0; i < n && kind != UHE_TOK_IN; i++) begin
      rx_valid <= 1'b1;
      rx_data <= pay[i];
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    if (kind != UHE_TOK_IN) begin
      rx_end <= 1'b1;
      rx_toggle <= tog;
      @(posedge clk_sys);
      rx_end <= 1'b0;
      rx_toggle <= ~tog;
    end
    gotn = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      if (resp_valid === 1'b1) break;
    end
    code = resp_code;
    if (code === UHE_HS_DATA) begin
      for (int k = 0; k < 12; k++) begin
        @(posedge clk_sys);
        if (tx_valid === 1'b1) begin
          got[gotn] = tx_data;
          gotn++;
        end
        if (tx_last === 1'b1) break;
      end
      host_ack <= 1'b1;
      @(posedge clk_sys);
      host_ack <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [uhe_hub_endpoints_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module uhe_hub_endpoints_tb_top
  import uhe_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout, hresp, tok_valid, rx_valid, rx_end, rx_toggle, host_ack;
  wire logic resp_valid, tx_valid, tx_last, irq;
  wire logic [31:0] hrdata;
  wire logic [1:0] tok_kind, resp_code;
  wire logic [3:0] tok_ep;
  wire logic [7:0] rx_data, tx_data;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'hd4c0d5a9;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic [7:0] tx_buf [8];
  logic [5:0] bm;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h18};
  logic [1:0] top [3] = '{2'b10, 2'b00, 2'b01};
  logic [1:0] ans [3] = '{UHE_HS_STALL, UHE_HS_NAK, UHE_HS_DATA};
  always #50 clk_sys = ~clk_sys;
  uhe_hub_endpoints DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_toggle(rx_toggle), .host_ack(host_ack), .resp_valid(resp_valid),
    .resp_code(resp_code), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .irq(irq));
  uhe_host_model host_m (.clk_sys(clk_sys), .resp_valid(resp_valid), .resp_code(resp_code),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_toggle(rx_toggle), .host_ack(host_ack));
  // ****
  // helpers
  // ****
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  function automatic logic [31:0] exp_st(logic tog, logic stp, logic fst, logic [3:0] cnt);
    return {24'h0, tog, stp, fst, 1'b0, cnt};
  endfunction
  // cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1, 8'h18, 32'hff);
    foreach (ra[i]) begin
      bus(0, ra[i], 32'h0);
      chk(rd, 32'h0, "reset or unmapped value");
    end
    host_m.xfer(UHE_TOK_OUT, 4'h0, 2, 1'b0);
    chk(host_m.code, UHE_HS_NAK, "out while disabled");
    for (int i = 0; i < 8; i++) host_m.pay[i] = 8'($random(seed));
    n = 1 + ($random(seed) & 7);
    bus(1, UHE_EP0_CTRL_ADDR, 32'h1);
    host_m.xfer(UHE_TOK_OUT, 4'h0, n, 1'b1);
    chk(host_m.code, UHE_HS_ACK, "out accepted");
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd & 32'hef, exp_st(1, 0, 0, 4'(n)), "status after out");
    for (int i = 0; i < n; i++) begin
      bus(0, UHE_DATA_BASE_ADDR + 8'(4 * i), 32'h0);
      chk(rd, {24'h0, host_m.pay[i]}, "rx byte");
    end
    bus(0, UHE_INT_STATUS_ADDR, 32'h0);
    chk(rd, 32'h1, "rx done");
    bus(1, UHE_INT_MASK_ADDR, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b1, "irq raised");
    host_m.xfer(UHE_TOK_OUT, 4'h0, 1, 1'b0);
    chk(host_m.code, UHE_HS_NAK, "out while rx done");
    bus(1, UHE_INT_STATUS_ADDR, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b0, "irq cleared");
    host_m.xfer(UHE_TOK_SETUP, 4'h0, 8, 1'b0);
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd & 32'hef, exp_st(0, 1, 0, 4'h8), "status after setup");
    bus(1, UHE_INT_STATUS_ADDR, 32'h1);
    host_m.xfer(UHE_TOK_IN, 4'h0, 0, 1'b0);
    chk(host_m.code, UHE_HS_NAK, "in while disabled");
    foreach (tx_buf[i]) begin
      tx_buf[i] = 8'($random(seed));
      bus(1, UHE_DATA_BASE_ADDR + 8'(4 * i), {24'h0, tx_buf[i]});
    end
    n = 1 + ($random(seed) & 7);
    bus(1, UHE_EP0_CTRL_ADDR, {24'h0, 4'(n), 4'h3});
    host_m.xfer(UHE_TOK_IN, 4'h0, 0, 1'b0);
    chk(host_m.gotn, n, "in byte count");
    for (int i = 0; i < n; i++) chk(host_m.got[i], tx_buf[i], "tx byte");
    bus(0, UHE_DATA_BASE_ADDR, 32'h0);
    chk(rd, {24'h0, host_m.pay[0]}, "data read is rx side");
    host_m.xfer(UHE_TOK_IN, 4'h0, 0, 1'b0);
    chk(host_m.code, UHE_HS_NAK, "in while tx done");
    host_m.xfer(UHE_TOK_OUT, 4'h0, 3, 1'b1);
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd & 32'hef, exp_st(1, 0, 1, 4'h3), "tx before rx set");
    bus(0, UHE_INT_STATUS_ADDR, 32'h0);
    chk(rd, 32'h3, "rx and tx done");
    bus(1, UHE_EP0_STATUS_ADDR, 32'h0);
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd[5], 1'b1, "zero write keeps flag");
    bus(1, UHE_EP0_STATUS_ADDR, 32'h10);
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd[5], 1'b0, "one write clears flag");
    bm = 6'($random(seed));
    for (int k = 0; k < 3; k++) begin
      bus(1, UHE_EP1_CTRL_ADDR, {24'h0, top[k], bm});
      host_m.xfer(UHE_TOK_IN, 4'h1, 0, 1'b0);
      chk(host_m.code, ans[k], "ep1 answer");
    end
    chk(host_m.got[0], {2'b00, bm}, "ep1 bitmap");
    bus(0, UHE_EP1_CTRL_ADDR, 32'h0);
    chk(rd, {24'h0, 2'b01, bm}, "ep1 readback");
    // reset in mid-run: controls clear, received byte count survives
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(0, UHE_EP0_STATUS_ADDR, 32'h0);
    chk(rd & 32'hef, exp_st(0, 0, 0, 4'h3), "status after reset");
    bus(0, UHE_EP0_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0, "ep0 ctrl after reset");
    bus(0, UHE_EP1_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0, "ep1 ctrl after reset");
    complete_run();
  end
endmodule
bind uhe_hub_endpoints uhe_hub_endpoints_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tok_valid(tok_valid),
  .tok_kind(tok_kind), .tok_ep(tok_ep), .resp_valid(resp_valid), .resp_code(resp_code),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
`default_nettype wire
